// *** hw/ptg_pkg.sv ***
// Shared constants and types of the profile timer generator block
package ptg_pkg;
  localparam int NUM_GEN = 8;
  localparam int MAX_SECT = 100;
  localparam int VAL_W = 32;
  localparam int SEG_W = 7;
  localparam int MEM_IDX_W = 10;
  localparam int ADDR_W = 15;
  localparam int NUM_SCHED = 7;

  // Byte offsets inside one generator block of 64 bytes
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_IDLE = 6'h04;
  localparam logic [5:0] REG_LOOP_COUNT = 6'h08;
  localparam logic [5:0] REG_SCHED_BASE = 6'h0C;
  localparam logic [5:0] REG_STATUS = 6'h28;
  localparam logic [5:0] REG_OUTPUT = 6'h2C;
  localparam int GEN_LSB = 6;

  // Section memory region: 0x2000 + gen*0x400 + sect*8 + word*4
  localparam logic [1:0] REGION_REGS = 2'h0;
  localparam logic [1:0] REGION_SECT = 2'h1;
  localparam int REGION_LSB = 13;
  localparam int SECT_GEN_LSB = 10;
  localparam int SECT_IDX_LSB = 3;
  localparam int SECT_WORD_BIT = 2;

  // Control register fields
  localparam int CTRL_TRIG_LSB = 0;
  localparam int CTRL_PAUSE_LSB = 4;
  localparam int CTRL_LOOP_LSB = 8;
  localparam int CTRL_RESTART_LSB = 16;
  localparam int CTRL_NSECT_LSB = 24;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] IDLE_RESET = 32'h0000_0000;
  localparam logic [31:0] LOOP_COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] SCHED_RESET = 32'h0000_0000;

  // Schedule word 0 holds months in the low bits, week days above
  localparam int MW_WDAY_LSB = 12;

  // Status register fields
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_PAUSE_BIT = 1;
  localparam int STAT_SEG_LSB = 8;
  localparam int STAT_CYC_LSB = 16;

  // Update tick rate and times
  localparam int TICK_HZ = 10;
  localparam int TRANS_MS = 100;
  localparam int TRANS_TICKS_RAW = (TICK_HZ * TRANS_MS) / 1000;
  localparam int TRANS_TICKS = (TRANS_TICKS_RAW < 1) ? 1 : TRANS_TICKS_RAW;
  localparam int SEC_PER_MIN = 60;
  localparam int SEC_PER_HOUR = 3600;

  typedef enum logic [2:0] {
    TRIG_OFF = 3'h0, TRIG_GATE = 3'h1, TRIG_ONCE = 3'h2,
    TRIG_RETRIG = 3'h3, TRIG_SCHED = 3'h4
  } ptg_trig_t;

  typedef enum logic [2:0] {
    PAUSE_OFF = 3'h0, PAUSE_HIGH = 3'h1, PAUSE_LOW = 3'h2,
    PAUSE_RISE = 3'h3, PAUSE_FALL = 3'h4
  } ptg_pause_t;

  typedef enum logic [1:0] {
    LOOP_ONCE = 2'h0, LOOP_COUNT = 2'h1, LOOP_CHAN = 2'h2, LOOP_INF = 2'h3
  } ptg_loop_t;

  typedef enum logic [1:0] {
    UNIT_SEC = 2'h0, UNIT_MIN = 2'h1, UNIT_HOUR = 2'h2
  } ptg_unit_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01, ST_RUN = 2'b10
  } ptg_state_t;

  typedef struct packed {
    logic ramp;
    logic [1:0] unit;
    logic [15:0] dur;
    logic [31:0] target;
  } ptg_sect_t;

  typedef struct packed {
    logic sec_strobe;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] wday;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } ptg_rtc_t;

  typedef struct packed {
    logic hit;
    logic sect;
    logic [2:0] gen;
    logic [5:0] off;
    logic [6:0] sidx;
    logic hi_word;
  } ptg_dec_t;
endpackage

// *** hw/ptg_src_det.sv ***
// Source sampler: level above zero and edges between update ticks
`timescale 1ns/1ps
module ptg_src_det (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sampling
  input wire logic tick,
  input wire logic signed [31:0] src_val,
  // Results, valid in a tick cycle
  output logic pos,
  output logic rise,
  output logic fall
);
  logic pos_ff;
  logic nxt_pos;
  logic now_pos;

  always_comb begin
    now_pos = src_val > 0;
    nxt_pos = tick ? now_pos : pos_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_ff <= 1'b0;
    end else begin
      pos_ff <= nxt_pos;
    end
  end

  // Level held from the last tick, so nothing reacts between ticks
  assign pos = nxt_pos;
  assign rise = tick & now_pos & ~pos_ff;
  assign fall = tick & ~now_pos & pos_ff;
endmodule

// *** hw/ptg_lerp.sv ***
// Linear interpolation between two points of a section
`timescale 1ns/1ps
module ptg_lerp #(
  parameter int W = 32
) (
  // End points
  input wire logic signed [W-1:0] from_val,
  input wire logic signed [W-1:0] to_val,
  // Position and span in ticks
  input wire logic [31:0] pos,
  input wire logic [31:0] span,
  // Interpolated value
  output logic signed [W-1:0] y
);
  localparam int PW = W + 34;
  logic signed [W:0] diff;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] quot;
  logic signed [W:0] sum;

  always_comb begin
    diff = $signed({to_val[W-1], to_val}) - $signed({from_val[W-1], from_val});
    prod = PW'(diff) * PW'($signed({1'b0, pos}));
    // Zero span would divide by zero; jump straight to the end point
    quot = (span == 32'h0) ? PW'(diff) : prod / PW'($signed({1'b0, span}));
    sum = $signed({from_val[W-1], from_val}) + $signed(quot[W:0]);
    y = sum[W-1:0];
  end
endmodule

// *** hw/ptg_top.sv ***
// Eight profile timer generators with an APB register file
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
// Functional notes
// - Eight independent generators, any output usable
// - Trigger modes: off, gate, once, retrig, schedule
// - Gate mode runs only while source above zero
// - Once mode: rising edge starts full run
// - Retrig mode: every rising edge restarts sequence
// - Schedule mode starts at selected calendar instants
// - Pause off: pause source ignored entirely
// - High pause: paused while source above zero
// - Low pause: paused while source at most zero
// - Level paused: triggers do not start sequence
// - Level paused output: first constant or idle
// - Rising pause edges toggle paused and running
// - Falling pause edges toggle paused and running
// - Edge paused: triggers handled as normal
// - Idle value before start and after finish
// - Up to one hundred sections run in order
// - Looping: once, counted, channel count, endless
// - Channel count: stop when cycles reach value
// - Repeats restart from configured section index
// - Section: duration, unit, shape, target value
// - Ramp goes linearly from previous target
// - Repeat on constant: short transition ramp
module ptg_top #(
  parameter int NUM_GEN = ptg_pkg::NUM_GEN,
  parameter int TICK_HZ = ptg_pkg::TICK_HZ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [ptg_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Update tick and calendar time
  input wire logic tick,
  input wire ptg_pkg::ptg_rtc_t rtc,
  // Logical channel values per generator
  input wire logic [NUM_GEN-1:0][31:0] trig_val,
  input wire logic [NUM_GEN-1:0][31:0] pause_val,
  input wire logic [NUM_GEN-1:0][31:0] loop_val,
  // Generator outputs
  output logic [NUM_GEN-1:0][31:0] gen_out
);
  localparam int NSLOT = NUM_GEN * ptg_pkg::MAX_SECT;
  localparam logic [31:0] TRANS_TICKS = 32'(ptg_pkg::TRANS_TICKS);

  // Configuration and section memory
  logic [31:0] ctrl_ff [NUM_GEN];
  logic [31:0] idle_ff [NUM_GEN];
  logic [31:0] lcnt_ff [NUM_GEN];
  logic [ptg_pkg::NUM_SCHED-1:0][31:0] sched_ff [NUM_GEN];
  ptg_pkg::ptg_sect_t sect_mem [NSLOT];
  logic [31:0] status_w [NUM_GEN];
  logic [31:0] out_w [NUM_GEN];

  // APB handshake
  logic pready_ff;
  logic nxt_pready;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pslverr_ff;
  logic nxt_pslverr;
  ptg_pkg::ptg_dec_t dec;
  logic [31:0] rd_data;
  logic wr_go;

  function automatic ptg_pkg::ptg_dec_t f_decode(
    input logic [ptg_pkg::ADDR_W-1:0] a
  );
    ptg_pkg::ptg_dec_t d;
    d = '0;
    if (a[ptg_pkg::ADDR_W-1:ptg_pkg::REGION_LSB] == ptg_pkg::REGION_SECT)
    begin
      d.sect = 1'b1;
      d.gen = a[ptg_pkg::SECT_GEN_LSB+:3];
      d.sidx = a[ptg_pkg::SECT_IDX_LSB+:7];
      d.hi_word = a[ptg_pkg::SECT_WORD_BIT];
      d.hit = (a[1:0] == 2'h0) &&
              (32'(d.sidx) < 32'(ptg_pkg::MAX_SECT)) &&
              (32'(d.gen) < 32'(NUM_GEN));
    end else if (a[ptg_pkg::ADDR_W-1:ptg_pkg::GEN_LSB+3] == '0) begin
      d.gen = a[ptg_pkg::GEN_LSB+:3];
      d.off = a[5:0];
      d.hit = (a[1:0] == 2'h0) && (d.off <= ptg_pkg::REG_OUTPUT) &&
              (32'(d.gen) < 32'(NUM_GEN));
    end
    return d;
  endfunction

  localparam int MEM_W = ptg_pkg::MEM_IDX_W;
  function automatic logic [MEM_W-1:0] f_slot(input logic [2:0] gen,
                                              input logic [6:0] s);
    return MEM_W'(32'(gen) * ptg_pkg::MAX_SECT + 32'(s));
  endfunction

  function automatic logic [31:0] f_merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i+:8] = new_v[8*i+:8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] f_sect_word0(input ptg_pkg::ptg_sect_t s);
    return {13'h0000, s.ramp, s.unit, s.dur};
  endfunction

  function automatic logic [3:0] f_sched_idx(input logic [5:0] off);
    return 4'((off - ptg_pkg::REG_SCHED_BASE) >> 2);
  endfunction

  always_comb begin
    dec = f_decode(paddr);
    rd_data = 32'h0000_0000;
    if (dec.hit && dec.sect) begin
      if (dec.hi_word) begin
        rd_data = sect_mem[f_slot(dec.gen, dec.sidx)].target;
      end else begin
        rd_data = f_sect_word0(sect_mem[f_slot(dec.gen, dec.sidx)]);
      end
    end else if (dec.hit) begin
      case (dec.off)
        ptg_pkg::REG_CTRL: rd_data = ctrl_ff[dec.gen];
        ptg_pkg::REG_IDLE: rd_data = idle_ff[dec.gen];
        ptg_pkg::REG_LOOP_COUNT: rd_data = lcnt_ff[dec.gen];
        ptg_pkg::REG_STATUS: rd_data = status_w[dec.gen];
        ptg_pkg::REG_OUTPUT: rd_data = out_w[dec.gen];
        default: rd_data = sched_ff[dec.gen][f_sched_idx(dec.off)];
      endcase
    end
    // One wait state so that every answer comes from a flip-flop
    nxt_pready = 1'b0;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (psel && penable && !pready_ff) begin
      nxt_pready = 1'b1;
      nxt_prdata = pwrite ? 32'h0000_0000 : rd_data;
      nxt_pslverr = !dec.hit;
    end
    wr_go = psel && penable && pready_ff && pwrite && dec.hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= nxt_pready;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Register file is a memory; writes land at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_GEN; i++) begin
        ctrl_ff[i] <= ptg_pkg::CTRL_RESET;
        idle_ff[i] <= ptg_pkg::IDLE_RESET;
        lcnt_ff[i] <= ptg_pkg::LOOP_COUNT_RESET;
        for (int k = 0; k < ptg_pkg::NUM_SCHED; k++) begin
          sched_ff[i][k] <= ptg_pkg::SCHED_RESET;
        end
      end
      for (int j = 0; j < NSLOT; j++) begin
        sect_mem[j] <= '0;
      end
    end else if (wr_go && dec.sect) begin
      if (dec.hi_word) begin
        sect_mem[f_slot(dec.gen, dec.sidx)].target <= f_merge(
          sect_mem[f_slot(dec.gen, dec.sidx)].target, pwdata, pstrb);
      end else begin
        {sect_mem[f_slot(dec.gen, dec.sidx)].ramp,
         sect_mem[f_slot(dec.gen, dec.sidx)].unit,
         sect_mem[f_slot(dec.gen, dec.sidx)].dur} <= 19'(f_merge(
          f_sect_word0(sect_mem[f_slot(dec.gen, dec.sidx)]), pwdata, pstrb));
      end
    end else if (wr_go) begin
      case (dec.off)
        ptg_pkg::REG_CTRL:
          ctrl_ff[dec.gen] <= f_merge(ctrl_ff[dec.gen], pwdata, pstrb);
        ptg_pkg::REG_IDLE:
          idle_ff[dec.gen] <= f_merge(idle_ff[dec.gen], pwdata, pstrb);
        ptg_pkg::REG_LOOP_COUNT:
          lcnt_ff[dec.gen] <= f_merge(lcnt_ff[dec.gen], pwdata, pstrb);
        ptg_pkg::REG_STATUS, ptg_pkg::REG_OUTPUT: begin
        end
        default:
          sched_ff[dec.gen][f_sched_idx(dec.off)] <= f_merge(
            sched_ff[dec.gen][f_sched_idx(dec.off)], pwdata, pstrb);
      endcase
    end
  end

  assign pready = pready_ff;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  function automatic logic [31:0] f_dur_ticks(input ptg_pkg::ptg_sect_t s);
    logic [31:0] mult;
    case (s.unit)
      ptg_pkg::UNIT_MIN: mult = 32'(ptg_pkg::SEC_PER_MIN);
      ptg_pkg::UNIT_HOUR: mult = 32'(ptg_pkg::SEC_PER_HOUR);
      default: mult = 32'h0000_0001;
    endcase
    return 32'(32'(s.dur) * mult * 32'(TICK_HZ));
  endfunction

  function automatic logic f_sched_hit(
    input logic [ptg_pkg::NUM_SCHED-1:0][31:0] m,
    input ptg_pkg::ptg_rtc_t r
  );
    logic [63:0] mins;
    logic [63:0] secs;
    logic [6:0] wd;
    mins = {m[4], m[3]};
    secs = {m[6], m[5]};
    wd = 7'(m[0] >> ptg_pkg::MW_WDAY_LSB);
    // An empty mask in any field never matches
    return r.sec_strobe && (r.month != 4'h0) && (r.month <= 4'hC) &&
           (r.day != 5'h00) && m[0][r.month - 4'h1] &&
           m[1][r.day - 5'h01] && wd[r.wday] && m[2][r.hour] &&
           mins[r.minute] && secs[r.second];
  endfunction

  function automatic logic f_again(input logic [1:0] mode,
                                   input logic [31:0] done,
                                   input logic [31:0] cnt,
                                   input logic [31:0] chan);
    case (mode)
      ptg_pkg::LOOP_COUNT: return done < cnt;
      ptg_pkg::LOOP_CHAN:
        return $signed({1'b0, done}) < $signed({chan[31], chan});
      ptg_pkg::LOOP_INF: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  for (genvar g = 0; g < NUM_GEN; g++) begin : gen_eng
    logic t_pos, t_rise, p_pos, p_rise, p_fall;
    ptg_pkg::ptg_state_t state_ff, nxt_state;
    logic [6:0] seg_ff, nxt_seg;
    logic [31:0] elap_ff, nxt_elap, cyc_ff, nxt_cyc;
    logic [31:0] prev_ff, nxt_prev, out_ff, nxt_out;
    logic pau_ff, nxt_pau, trans_ff, nxt_trans;
    logic gdone_ff, nxt_gdone, pend_ff, nxt_pend;
    logic [2:0] tmode, pmode;
    logic [1:0] lmode;
    logic [6:0] nsect, rstart;
    logic lvl_pause, start, hit;
    ptg_pkg::ptg_sect_t cur, first;
    logic [31:0] dur, span, lerp_y;

    ptg_src_det u_trig (
      .pclk(pclk), .presetn(presetn), .tick(tick),
      .src_val(trig_val[g]), .pos(t_pos), .rise(t_rise), .fall()
    );
    ptg_src_det u_pause (
      .pclk(pclk), .presetn(presetn), .tick(tick),
      .src_val(pause_val[g]), .pos(p_pos), .rise(p_rise), .fall(p_fall)
    );
    ptg_lerp #(.W(32)) u_lerp (
      .from_val(prev_ff), .to_val(cur.target), .pos(elap_ff),
      .span(span), .y(lerp_y)
    );

    always_comb begin
      tmode = ctrl_ff[g][ptg_pkg::CTRL_TRIG_LSB+:3];
      pmode = ctrl_ff[g][ptg_pkg::CTRL_PAUSE_LSB+:3];
      lmode = ctrl_ff[g][ptg_pkg::CTRL_LOOP_LSB+:2];
      nsect = ctrl_ff[g][ptg_pkg::CTRL_NSECT_LSB+:7];
      if (32'(nsect) > ptg_pkg::MAX_SECT) begin
        nsect = 7'(ptg_pkg::MAX_SECT);
      end
      rstart = ctrl_ff[g][ptg_pkg::CTRL_RESTART_LSB+:7];
      if (rstart >= nsect) begin
        rstart = 7'h00;
      end
      cur = sect_mem[f_slot(3'(g), seg_ff)];
      first = sect_mem[f_slot(3'(g), 7'h00)];
      dur = f_dur_ticks(cur);
      span = cur.ramp ? dur : TRANS_TICKS;
      hit = f_sched_hit(sched_ff[g], rtc);
      lvl_pause = (pmode == ptg_pkg::PAUSE_HIGH && p_pos) ||
                  (pmode == ptg_pkg::PAUSE_LOW && !p_pos);
      nxt_state = state_ff;
      nxt_seg = seg_ff;
      nxt_elap = elap_ff;
      nxt_cyc = cyc_ff;
      nxt_prev = prev_ff;
      nxt_pau = pau_ff;
      nxt_trans = trans_ff;
      nxt_gdone = gdone_ff;
      nxt_pend = pend_ff | hit;
      start = 1'b0;
      if (tick) begin
        // A hit in the tick cycle is used now; latching it would start twice
        nxt_pend = 1'b0;
        case (tmode)
          ptg_pkg::TRIG_GATE: start = t_pos && state_ff == ptg_pkg::ST_IDLE &&
                                      !gdone_ff;
          ptg_pkg::TRIG_ONCE: start = t_rise &&
                                      state_ff == ptg_pkg::ST_IDLE;
          ptg_pkg::TRIG_RETRIG: start = t_rise;
          ptg_pkg::TRIG_SCHED: start = (pend_ff || hit) &&
                                       state_ff == ptg_pkg::ST_IDLE;
          default: start = 1'b0;
        endcase
        if (nsect == 7'h00 || lvl_pause) begin
          start = 1'b0;
        end
        if ((pmode == ptg_pkg::PAUSE_RISE && p_rise) ||
            (pmode == ptg_pkg::PAUSE_FALL && p_fall)) begin
          nxt_pau = !pau_ff;
        end else if (pmode != ptg_pkg::PAUSE_RISE &&
                     pmode != ptg_pkg::PAUSE_FALL) begin
          nxt_pau = 1'b0;
        end
        if (!t_pos) begin
          nxt_gdone = 1'b0;
        end
        if (tmode == ptg_pkg::TRIG_OFF ||
            (tmode == ptg_pkg::TRIG_GATE && !t_pos)) begin
          nxt_state = ptg_pkg::ST_IDLE;
        end else if (start) begin
          nxt_state = ptg_pkg::ST_RUN;
          nxt_seg = 7'h00;
          nxt_elap = 32'h0000_0000;
          nxt_cyc = 32'h0000_0000;
          nxt_prev = idle_ff[g];
          nxt_trans = 1'b0;
        end else if (state_ff == ptg_pkg::ST_RUN && !lvl_pause &&
                     !pau_ff) begin
          if (elap_ff + 32'h0000_0001 >= dur) begin
            nxt_prev = cur.target;
            nxt_elap = 32'h0000_0000;
            nxt_trans = 1'b0;
            if (seg_ff + 7'h01 < nsect) begin
              nxt_seg = seg_ff + 7'h01;
            end else begin
              nxt_cyc = cyc_ff + 32'h0000_0001;
              if (f_again(lmode, nxt_cyc, lcnt_ff[g], loop_val[g])) begin
                nxt_seg = rstart;
                nxt_trans = 1'b1;
              end else begin
                nxt_state = ptg_pkg::ST_IDLE;
                nxt_gdone = 1'b1;
              end
            end
          end else begin
            nxt_elap = elap_ff + 32'h0000_0001;
          end
        end
      end
      // Output follows the state of the current cycle
      if (tmode != ptg_pkg::TRIG_OFF && lvl_pause) begin
        nxt_out = first.ramp ? idle_ff[g] : first.target;
      end else if (state_ff != ptg_pkg::ST_RUN) begin
        nxt_out = idle_ff[g];
      end else if (pau_ff) begin
        nxt_out = out_ff;
      end else if (cur.ramp) begin
        nxt_out = lerp_y;
      end else if (trans_ff && elap_ff < TRANS_TICKS) begin
        nxt_out = lerp_y;
      end else begin
        nxt_out = cur.target;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        state_ff <= ptg_pkg::ST_IDLE;
        seg_ff <= 7'h00;
        elap_ff <= 32'h0000_0000;
        cyc_ff <= 32'h0000_0000;
        prev_ff <= 32'h0000_0000;
        out_ff <= 32'h0000_0000;
        pau_ff <= 1'b0;
        trans_ff <= 1'b0;
        gdone_ff <= 1'b0;
        pend_ff <= 1'b0;
      end else begin
        state_ff <= nxt_state;
        seg_ff <= nxt_seg;
        elap_ff <= nxt_elap;
        cyc_ff <= nxt_cyc;
        prev_ff <= nxt_prev;
        out_ff <= nxt_out;
        pau_ff <= nxt_pau;
        trans_ff <= nxt_trans;
        gdone_ff <= nxt_gdone;
        pend_ff <= nxt_pend;
      end
    end

    always_comb begin
      status_w[g] = 32'h0000_0000;
      status_w[g][ptg_pkg::STAT_RUN_BIT] = state_ff == ptg_pkg::ST_RUN;
      status_w[g][ptg_pkg::STAT_PAUSE_BIT] = pau_ff || lvl_pause;
      status_w[g][ptg_pkg::STAT_SEG_LSB+:7] = seg_ff;
      status_w[g][ptg_pkg::STAT_CYC_LSB+:16] = cyc_ff[15:0];
      out_w[g] = out_ff;
    end
    assign gen_out[g] = out_ff;
  end
endmodule

// *** dv/ptg_chan_model.sv ***
// Logical channel values feeding generator zero
`timescale 1ns/1ps
module ptg_chan_model (
  // Clock
  input wire logic pclk,
  // Channel values
  output logic [7:0][31:0] trig_val,
  output logic [7:0][31:0] pause_val,
  output logic [7:0][31:0] loop_val
);
  initial begin
    trig_val = '0;
    pause_val = '0;
    loop_val = '0;
  end
  // Moves just after an edge; the block only looks on ticks
  task automatic put(input int k, input logic [31:0] v);
    @(posedge pclk);
    if (k == 0)
      trig_val[0] <= v;
    else if (k == 1)
      pause_val[0] <= v;
    else
      loop_val[0] <= v;
  endtask
endmodule

// *** dv/ptg_top_chk.sv ***
// Port assertions of the profile timer generator
`timescale 1ns/1ps
module ptg_top_chk #(
  parameter int NUM_GEN = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [ptg_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // Profile side
  input wire logic tick,
  input wire logic [NUM_GEN-1:0][31:0] gen_out
);
  logic quiet;
  logic acc;
  assign quiet = !tick && !(psel && pwrite);
  assign acc = psel && penable && pready;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing in second access cycle");
  rdy_sel_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  rdy_once_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_rdy_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  hi_region_a: assert property (acc && paddr[14] |-> pslverr)
    else $error("unmapped region accepted");
  mis_align_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access accepted");
  rst_out_a: assert property ($rose(presetn) |-> gen_out == '0)
    else $error("output not cleared by reset");
  out_quiet_a: assert property (quiet [*4] |=> $stable(gen_out))
    else $error("output moved without tick or write");
  cover property (acc && pslverr);
  cover property (acc && pwrite);
  cover property (tick ##2 $changed(gen_out));
endmodule
bind ptg_top ptg_top_chk #(.NUM_GEN(NUM_GEN)) u_chk (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .tick(tick),
  .gen_out(gen_out));

// *** dv/ptg_top_tb.sv ***
// Self-checking bench of the profile timer generator
`timescale 1ns/1ps
module ptg_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic tick = 0, pready, pslverr, rerr;
  ptg_pkg::ptg_rtc_t rtc = '0;
  logic [ptg_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic [7:0][31:0] trig_val, pause_val, loop_val, gen_out;
  logic [2:0] tcnt = '0;
  int n_errors = 0, n_compared = 0, cyc = 0;
  int lm[4] = '{1, 2, 2, 3};
  ptg_chan_model CH (.pclk(pclk), .trig_val(trig_val),
    .pause_val(pause_val), .loop_val(loop_val));
  ptg_top #(.TICK_HZ(1)) DUT (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tick(tick), .rtc(rtc), .trig_val(trig_val),
    .pause_val(pause_val), .loop_val(loop_val), .gen_out(gen_out));
  initial begin
    forever #4 pclk = ~pclk;
  end
  // Tick every eighth cycle leaves quiet gaps between updates
  always @(posedge pclk) begin
    tcnt <= tcnt + 3'h1;
    tick <= (tcnt == 3'h7);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input int a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a[14:0];
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge pclk iff tick);
    repeat (3) @(posedge pclk);
  endtask
  function automatic logic [31:0] cw(int t, int p, int l);
    return t | (p << ptg_pkg::CTRL_PAUSE_LSB) | (l << ptg_pkg::CTRL_LOOP_LSB)
      | (1 << ptg_pkg::CTRL_RESTART_LSB) | (2 << ptg_pkg::CTRL_NSECT_LSB);
  endfunction
  // Trigger rises, two ticks later the run sits in section zero
  task automatic go(input logic [31:0] c);
    apb(1, 'h0, c);
    CH.put(0, 1);
    tk(2);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    apb(0, 'h0, 0);
    chk("ctrl", 0, rdat);
    apb(0, 'h7FFC, 0);
    chk("unmapped", 1, rerr);
    apb(0, 'h2, 0);
    chk("align", 1, rerr);
    apb(1, 'h28, 32'hFFFF_FFFF);
    apb(0, 'h28, 0);
    chk("status", 0, rdat);
    $display("test registers done");
    apb(1, 'h4, 5);
    apb(1, 'h2000, 4);
    apb(1, 'h2004, 100);
    apb(1, 'h2008, 4);
    apb(1, 'h200C, 200);
    apb(1, 'h8, 2);
    tk(1);
    chk("idle", 5, gen_out[0]);
    go(cw(2, 0, 0));
    chk("once s0", 100, gen_out[0]);
    CH.put(0, 0);
    tk(4);
    chk("once s1", 200, gen_out[0]);
    tk(4);
    chk("once end", 5, gen_out[0]);
    go(cw(3, 0, 0));
    tk(4);
    CH.put(0, 0);
    tk(1);
    CH.put(0, 1);
    tk(2);
    chk("retrig", 100, gen_out[0]);
    CH.put(0, 32'hFFFF_FFFF);
    tk(10);
    apb(1, 'h0, cw(1, 0, 0));
    tk(3);
    chk("gate neg", 5, gen_out[0]);
    CH.put(0, 1);
    tk(2);
    chk("gate on", 100, gen_out[0]);
    CH.put(0, 0);
    tk(2);
    chk("gate off", 5, gen_out[0]);
    $display("test triggers done");
    go(cw(2, 1, 0));
    CH.put(1, 1);
    tk(6);
    apb(0, 'h28, 0);
    chk("paused", 1, rdat[1]);
    chk("pause out", 100, gen_out[0]);
    CH.put(1, 0);
    CH.put(0, 0);
    tk(5);
    chk("resumed", 200, gen_out[0]);
    tk(8);
    $display("test pause done");
    // Pause source held high while pause is off must not matter
    CH.put(1, 1);
    for (int i = 0; i < 4; i++) begin
      CH.put(2, i);
      go(cw(2, 0, lm[i]));
      CH.put(0, 0);
      tk(8);
      chk("loop", (i == 1) ? 5 : 200, gen_out[0]);
      tk(8);
      chk("loop end", (i == 3) ? 200 : 5, gen_out[0]);
    end
    apb(1, 'h0, 0);
    tk(3);
    chk("off", 5, gen_out[0]);
    $display("test loops done");
    // Section 0 ramps from idle 5 to 45 over four ticks
    apb(1, 'h2000, 32'h0004_0004);
    apb(1, 'h2004, 45);
    go(cw(2, 4, 0));
    chk("ramp", 15, gen_out[0]);
    CH.put(1, 0);
    tk(4);
    apb(0, 'h28, 0);
    chk("edge paused", 1, rdat[1]);
    // A rising pause edge must not toggle in falling mode
    CH.put(1, 1);
    tk(2);
    CH.put(1, 0);
    tk(1);
    chk("edge resumed", 25, gen_out[0]);
    tk(8);
    $display("test ramp and edge pause done");
    for (int k = 0; k < 7; k++) begin
      apb(1, 'hC + 4 * k, 32'hFFFF_FFFF);
    end
    rtc.month <= 4'h1;
    rtc.day <= 5'h01;
    apb(1, 'h0, cw(4, 0, 0));
    tk(2);
    chk("sched wait", 5, gen_out[0]);
    rtc.sec_strobe <= 1'h1;
    @(posedge pclk);
    rtc.sec_strobe <= 1'h0;
    tk(2);
    chk("sched", 15, gen_out[0]);
    $display("test schedule done");
    end_sim();
  end
endmodule
